// *** hdl/rdc_calib.sv ***
// Digital rate calibration of the oscillator divider chain
// Function
// - Crystal selected: correct at 16.384 kHz tap
// - Normal crystal mode: offset pulses per 32 s
// - Coarse crystal mode: offset pulses per 16 s
// - Crystal step 1.907 or 3.814 ppm
// - Crystal offset signed, -64 to +63
// - Extended slowdown: 122 ppm per unit
// - Crystal corrections spread evenly over window
// - RC selected: correct at 64 Hz tap
// - RC range 00: window 8,192 s
// - RC range 01: window 4,096 s
// - RC range 10: window 2,048 s
// - RC range 11: window 1,024 s
// - RC offset signed, -8,192 to +8,191
// - RC corrections spread evenly over window
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module rdc_calib
   import rdc_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire logic              OSC_IN,
   input  wire logic [ADDR_W-1:0] ADDRESS,
   input  wire logic              READ,
   input  wire logic              WRITE,
   input  wire logic [DATA_W-1:0] WRITEDATA,
   input  wire logic [3:0]        BYTEENABLE,
   output logic      [DATA_W-1:0] READDATA,
   output logic                   WAITREQUEST,
   output logic                   CAL_TAP_PULSE,
   output logic                   WINDOW_START,
   output logic                   OSC_ACTIVE
);
   rdc_cfg_type      cfg_q;
   rdc_cfg_type      cfg_d;
   rdc_cfg_type      act_q;
   rdc_cfg_type      act_d;
   rdc_cfg_type      eff;
   rdc_bus_type      bus_q;
   rdc_bus_type      bus_d;
   rdc_act_type      action_q;
   rdc_act_type      action_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic              wait_q;
   logic              wait_d;
   logic              osc_s;
   logic              osc_prev_q;
   logic              osc_prev_d;
   logic              half_q;
   logic              half_d;
   logic [POS_W-1:0]  pos_q;
   logic [POS_W-1:0]  pos_d;
   logic              pulse_q;
   logic              pulse_d;
   logic              wstart_q;
   logic              wstart_d;
   logic              tick;
   logic              cyc_start;
   logic              boundary;
   logic              fire;
   logic [POS_W-1:0]  len;
   logic [AMT_W-1:0]  xt_signed;
   logic [AMT_W-1:0]  ext_steps;
   logic [AMT_W-1:0]  net;
   logic [AMT_W-1:0]  mag;
   logic              negative;
   logic [DATA_W-1:0] ctrl_img;
   logic [DATA_W-1:0] actv_img;
   logic [DATA_W-1:0] wr_img;
   logic [DATA_W-1:0] old_img;

   function automatic logic [DATA_W-1:0] ctrl_word(input rdc_cfg_type c);
      logic [DATA_W-1:0] w;
      w = '0;
      w[CTRL_OSCILLATOR_SELECT_BIT]                 = c.oscillator_select;
      w[CTRL_COARSE_BIT]               = c.coarse;
      w[CTRL_EXT_LSB +: 2]             = c.ext;
      w[CTRL_RANGE_LSB +: 2]           = c.range;
      return w;
   endfunction

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] wd,
      input logic [3:0]        be
   );
      logic [DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Oscillator arrives on a pin, so it is synchronised before use
   rdc_sync u_osc_sync (
      .clk  (CLK),
      .rst  (RESET),
      .din  (OSC_IN),
      .dout (osc_s)
   );

   // Only rising pin edges count, so the duty cycle does not matter
   assign tick      = osc_s && !osc_prev_q;
   // Stage clock is the oscillator halved: 16.384 kHz or 64 Hz
   assign cyc_start = tick && !half_q;

   // Settings change only at a window edge or on oscillator switch
   // A switch restarts the window, so no window mixes two sources
   assign boundary  = (pos_q == len - 20'h00001) ||
                      (cfg_q.oscillator_select != act_q.oscillator_select);
   assign eff       = boundary ? cfg_q : act_q;

   // Signed correction count for the selected oscillator
   // Extended slowdown is crystal only; it never touches the RC count
   always_comb begin
      xt_signed = {{(AMT_W-XOFF_W){eff.xoff[XOFF_W-1]}}, eff.xoff};
      ext_steps = AMT_W'(eff.ext) *
                  (eff.coarse ? EXT_STEPS_COARSE : EXT_STEPS_NORM);
      if (!eff.oscillator_select) begin
         net = xt_signed - ext_steps;
      end else begin
         net = {{(AMT_W-ROFF_W){eff.roff[ROFF_W-1]}}, eff.roff};
      end
      negative = net[AMT_W-1];
      mag      = negative ? AMT_W'(-net) : net;
   end

   // Window length in stage cycles
   // Range field is ignored while the crystal is active
   always_comb begin
      if (!eff.oscillator_select) begin
         len = eff.coarse ? XT_WIN_COARSE_CYC : XT_WIN_NORM_CYC;
      end else begin
         case (eff.range)
            2'b00:   len = RC_WIN0_CYC;
            2'b01:   len = RC_WIN1_CYC;
            2'b10:   len = RC_WIN2_CYC;
            2'b11:   len = RC_WIN3_CYC;
            default: len = RC_WIN0_CYC;
         endcase
      end
   end

   // Carry spreading keeps jitter to one stage period
   // Restart per window, so rounding never carries into the next one
   rdc_spread #(
      .W (POS_W)
   ) u_spread (
      .clk     (CLK),
      .rst     (RESET),
      .step    (cyc_start),
      .restart (boundary),
      .amount  (POS_W'(mag)),
      .len     (len),
      .fire    (fire)
   );

   // Divider tap, window position and pulse shaping
   always_comb begin
      osc_prev_d = osc_s;
      half_d     = half_q;
      pos_d      = pos_q;
      act_d      = act_q;
      action_d   = action_q;
      wstart_d   = 1'b0;
      pulse_d    = 1'b0;
      if (tick) begin
         half_d = !half_q;
      end
      // Limitation: first window after reset is one stage cycle short
      if (cyc_start) begin
         if (boundary) begin
            pos_d    = POS_RESET;
            act_d    = cfg_q;
            wstart_d = 1'b1;
         end else begin
            pos_d = pos_q + 20'h00001;
         end
         if (!fire) begin
            action_d = ACT_NONE;
         end else if (negative) begin
            action_d = ACT_GATE;
         end else begin
            action_d = ACT_INSERT;
         end
         // Insertion puts a full-rate pulse in the first half too
         pulse_d = (action_d == ACT_INSERT);
      end else if (tick) begin
         // Gating drops the one normal pulse of this stage cycle
         pulse_d = (action_q != ACT_GATE);
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         osc_prev_q <= 1'b0;
         half_q     <= 1'b0;
         pos_q      <= POS_RESET;
         act_q      <= CFG_RESET;
         action_q   <= ACT_NONE;
         wstart_q   <= 1'b0;
         pulse_q    <= 1'b0;
      end else begin
         osc_prev_q <= osc_prev_d;
         half_q     <= half_d;
         pos_q      <= pos_d;
         act_q      <= act_d;
         action_q   <= action_d;
         wstart_q   <= wstart_d;
         pulse_q    <= pulse_d;
      end
   end

   // Register images for read-back and byte-lane merge
   always_comb begin
      ctrl_img = ctrl_word(cfg_q);
      actv_img = ctrl_word(act_q);
      case (ADDRESS)
         CTRL_OFS: old_img = ctrl_img;
         XOFF_OFS: old_img = DATA_W'(cfg_q.xoff);
         ROFF_OFS: old_img = DATA_W'(cfg_q.roff);
         ACTV_OFS: old_img = actv_img;
         WPOS_OFS: old_img = DATA_W'(pos_q);
         default:  old_img = '0;
      endcase
      wr_img = merge(old_img, WRITEDATA, BYTEENABLE);
   end

   // Avalon slave: one wait cycle, write commits on the accept edge
   always_comb begin
      bus_d   = bus_q;
      wait_d  = wait_q;
      rdata_d = rdata_q;
      cfg_d   = cfg_q;
      case (bus_q)
         BUS_IDLE: begin
            if (READ || WRITE) begin
               bus_d  = BUS_ACK;
               wait_d = 1'b0;
               // Taken on the request edge so it stands all answer cycle
               if (READ) begin
                  rdata_d = old_img;
               end
            end
         end
         BUS_ACK: begin
            bus_d  = BUS_IDLE;
            wait_d = 1'b1;
            if (WRITE) begin
               case (ADDRESS)
                  CTRL_OFS: begin
                     cfg_d.oscillator_select   = wr_img[CTRL_OSCILLATOR_SELECT_BIT];
                     cfg_d.coarse = wr_img[CTRL_COARSE_BIT];
                     cfg_d.ext    = wr_img[CTRL_EXT_LSB +: 2];
                     cfg_d.range  = wr_img[CTRL_RANGE_LSB +: 2];
                  end
                  XOFF_OFS: cfg_d.xoff = wr_img[XOFF_W-1:0];
                  ROFF_OFS: cfg_d.roff = wr_img[ROFF_W-1:0];
                  default:  cfg_d = cfg_q;
               endcase
            end
         end
         default: begin
            bus_d  = BUS_IDLE;
            wait_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         bus_q   <= BUS_IDLE;
         wait_q  <= 1'b1;
         rdata_q <= '0;
         cfg_q   <= CFG_RESET;
      end else begin
         bus_q   <= bus_d;
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         cfg_q   <= cfg_d;
      end
   end

   // Every pin comes straight from a flop, so strobes never glitch
   // Pulses last one clock; a slower consumer must stretch them itself
   assign READDATA      = rdata_q;
   assign WAITREQUEST   = wait_q;
   assign CAL_TAP_PULSE = pulse_q;
   assign WINDOW_START  = wstart_q;
   assign OSC_ACTIVE    = act_q.oscillator_select;
endmodule

// *** hdl/rdc_pkg.sv ***
// Constants, register map and types for the rate calibration block
package rdc_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int POS_W  = 20;
   localparam int AMT_W  = 16;
   localparam int XOFF_W = 7;
   localparam int ROFF_W = 14;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
   localparam logic [ADDR_W-1:0] XOFF_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] ROFF_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] ACTV_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] WPOS_OFS = 5'h10;

   // Control field positions
   localparam int CTRL_OSCILLATOR_SELECT_BIT   = 0;
   localparam int CTRL_COARSE_BIT = 1;
   localparam int CTRL_EXT_LSB    = 2;
   localparam int CTRL_RANGE_LSB  = 4;

   // Divider stage rates and window lengths
   localparam int XT_STAGE_HZ     = 16384;
   localparam int RC_STAGE_HZ     = 64;
   localparam int XT_WIN_NORM_S   = 32;
   localparam int XT_WIN_COARSE_S = 16;
   localparam int RC_WIN0_S       = 8192;
   localparam int RC_WIN1_S       = 4096;
   localparam int RC_WIN2_S       = 2048;
   localparam int RC_WIN3_S       = 1024;
   localparam logic [POS_W-1:0] XT_WIN_NORM_CYC   =
      POS_W'(XT_WIN_NORM_S * XT_STAGE_HZ);
   localparam logic [POS_W-1:0] XT_WIN_COARSE_CYC =
      POS_W'(XT_WIN_COARSE_S * XT_STAGE_HZ);
   localparam logic [POS_W-1:0] RC_WIN0_CYC = POS_W'(RC_WIN0_S * RC_STAGE_HZ);
   localparam logic [POS_W-1:0] RC_WIN1_CYC = POS_W'(RC_WIN1_S * RC_STAGE_HZ);
   localparam logic [POS_W-1:0] RC_WIN2_CYC = POS_W'(RC_WIN2_S * RC_STAGE_HZ);
   localparam logic [POS_W-1:0] RC_WIN3_CYC = POS_W'(RC_WIN3_S * RC_STAGE_HZ);

   // Steps per 122 ppm of extended slowdown
   localparam logic [AMT_W-1:0] EXT_STEPS_NORM   = 16'h0040;
   localparam logic [AMT_W-1:0] EXT_STEPS_COARSE = 16'h0020;

   typedef struct packed {
      logic              oscillator_select;
      logic              coarse;
      logic [1:0]        ext;
      logic [1:0]        range;
      logic [XOFF_W-1:0] xoff;
      logic [ROFF_W-1:0] roff;
   } rdc_cfg_type;

   localparam rdc_cfg_type CFG_RESET = '0;
   localparam logic [POS_W-1:0] POS_RESET = 20'h00000;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } rdc_bus_type;

   typedef enum logic [2:0] {
      ACT_NONE   = 3'b001,
      ACT_GATE   = 3'b010,
      ACT_INSERT = 3'b100
   } rdc_act_type;
endpackage

// *** hdl/rdc_sync.sv ***
// Two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module rdc_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule

// *** hdl/rdc_spread.sv ***
// Accumulator that spreads a correction count evenly over a window
`timescale 1ns/1ps
module rdc_spread #(
   parameter int W = 20
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         step,
   input  wire logic         restart,
   input  wire logic [W-1:0] amount,
   input  wire logic [W-1:0] len,
   output logic              fire
);
   logic [W-1:0] acc_q;
   logic [W-1:0] acc_d;
   logic [W-1:0] base;
   logic [W-1:0] sum;

   // Carry-style spreading: one fire per len/amount steps, exact per window
   always_comb begin
      base  = restart ? '0 : acc_q;
      sum   = base + amount;
      fire  = step && (sum >= len);
      acc_d = acc_q;
      if (step) begin
         acc_d = (sum >= len) ? sum - len : sum;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end
endmodule

// *** verification/rdc_osc_model.sv ***
// Free-running oscillator that feeds the calibration block's pin
`timescale 1ns/1ps
module rdc_osc_model #(
   parameter int HALF_NS = 100
) (
   input  wire logic run,
   output logic      osc
);
   initial osc = 1'b0;
   // Parked low when stopped so the pin never shows a stale edge
   always begin
      #(HALF_NS);
      osc = run ? ~osc : 1'b0;
   end
endmodule

// *** verification/rdc_calib_chk.sv ***
// Port checks for the rate calibration block
`timescale 1ns/1ps
module rdc_calib_chk
   import rdc_pkg::*;
(
   input wire logic              CLK,
   input wire logic              RESET,
   input wire logic              OSC_IN,
   input wire logic [ADDR_W-1:0] ADDRESS,
   input wire logic              READ,
   input wire logic              WRITE,
   input wire logic [DATA_W-1:0] WRITEDATA,
   input wire logic [3:0]        BYTEENABLE,
   input wire logic [DATA_W-1:0] READDATA,
   input wire logic              WAITREQUEST,
   input wire logic              CAL_TAP_PULSE,
   input wire logic              WINDOW_START,
   input wire logic              OSC_ACTIVE
);
   logic       osc_q;
   logic [3:0] age_q;
   logic [3:0] age_d;
   // Age of the last pin rise; saturates so idle spans never wrap
   always_comb begin
      age_d = age_q;
      if (OSC_IN && !osc_q) begin
         age_d = 4'h0;
      end else if (age_q != 4'hF) begin
         age_d = age_q + 4'h1;
      end
   end
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         osc_q <= 1'b0;
         age_q <= 4'hF;
      end else begin
         osc_q <= OSC_IN;
         age_q <= age_d;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   chk_pulse_cause: assert property (
      CAL_TAP_PULSE |-> age_q inside {[1:5]})
      else $error("tap pulse without oscillator edge");
   chk_pulse_single: assert property (
      CAL_TAP_PULSE |=> !CAL_TAP_PULSE [*3])
      else $error("tap pulse too long");
   chk_win_edge: assert property (
      WINDOW_START |-> age_q inside {[1:5]})
      else $error("window start off a stage edge");
   chk_win_spacing: assert property (
      WINDOW_START |=> !WINDOW_START [*7])
      else $error("window start repeated");
   chk_oscillator_select_edge: assert property (
      $changed(OSC_ACTIVE) |-> age_q inside {[1:6]})
      else $error("source switched off a stage edge");
   chk_answer_next: assert property (
      (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
      else $error("bus answer late");
   chk_answer_once: assert property (!WAITREQUEST |=> WAITREQUEST)
      else $error("bus answer held");
   chk_answer_cause: assert property (
      !WAITREQUEST |-> $past(READ) || $past(WRITE))
      else $error("bus answer without request");
   chk_rdata_hold: assert property (
      $changed(READDATA) |-> !WAITREQUEST && $past(READ))
      else $error("read data moved outside an answer");
   cover property (WINDOW_START && OSC_ACTIVE);
   cover property (CAL_TAP_PULSE && !OSC_ACTIVE);
   cover property (!WAITREQUEST && READ);
endmodule
bind rdc_calib rdc_calib_chk chk_i (
   .CLK(CLK), .RESET(RESET), .OSC_IN(OSC_IN), .ADDRESS(ADDRESS),
   .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
   .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
   .CAL_TAP_PULSE(CAL_TAP_PULSE), .WINDOW_START(WINDOW_START),
   .OSC_ACTIVE(OSC_ACTIVE)
);

// *** verification/tb.sv ***
// Self-checking bench for the rate calibration block
`timescale 1ns/1ps
module tb
   import rdc_pkg::*;
;
   localparam int STAGE_CLK = 16;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic              osc_run = 1'b0;
   logic              osc_pin;
   logic [ADDR_W-1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [DATA_W-1:0] writedata = '0;
   logic [3:0]        byteenable = '0;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   logic              cal_tap_pulse;
   logic              window_start;
   logic              osc_active;
   logic [31:0]       lfsr_q = 32'h0F13;
   int                failures = 0;
   int                checks_done = 0;
   int                lens [$];
   always #12.5 clk = ~clk;
   rdc_calib dut (
      .CLK(clk), .RESET(reset), .OSC_IN(osc_pin), .ADDRESS(address),
      .READ(read), .WRITE(write), .WRITEDATA(writedata),
      .BYTEENABLE(byteenable), .READDATA(readdata),
      .WAITREQUEST(waitrequest), .CAL_TAP_PULSE(cal_tap_pulse),
      .WINDOW_START(window_start), .OSC_ACTIVE(osc_active)
   );
   rdc_osc_model osc_i (
      .run(osc_run),
      .osc(osc_pin)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int exp_cnt(input int s, input int net, input int len);
      return net < 0 ? s - (-net * s) / len : s + (net * s) / len;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [3:0] be,
                      output logic [DATA_W-1:0] rd);
      int k;
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      byteenable <= be;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 100);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (k >= 100) failures++;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] x;
      bus(1'b1, a, d, 4'hF, x);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                     input string what);
      logic [DATA_W-1:0] x;
      bus(1'b0, a, '0, 4'hF, x);
      check(x, e, what);
   endtask
   // Counts tap pulses over s stage cycles from the next window start
   task automatic meas(input int s, output int cnt, output int mg);
      int k;
      int last;
      k = 0;
      cnt = 0;
      mg = 0;
      last = 0;
      while (window_start !== 1'b1 && k < 4000) begin
         @(posedge clk);
         k++;
      end
      for (int i = 0; i < STAGE_CLK * s; i++) begin
         if (cal_tap_pulse === 1'b1) begin
            if (cnt > 0 && i - last > mg) mg = i - last;
            cnt++;
            last = i;
         end
         @(posedge clk);
      end
      if (k >= 4000) failures++;
   endtask
   initial begin
      logic [DATA_W-1:0] v;
      int                cnt;
      int                mg;
      int                e;
      lens = {int'(RC_WIN0_CYC), int'(RC_WIN1_CYC), int'(RC_WIN2_CYC),
               int'(RC_WIN3_CYC)};
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      osc_run <= 1'b1;
      rd(CTRL_OFS, '0, "ctrl reset");
      lfsr_q = lfsr(lfsr_q);
      wr(XOFF_OFS, lfsr_q);
      rd(XOFF_OFS, {25'h0, lfsr_q[6:0]}, "xoff");
      bus(1'b1, CTRL_OFS, 32'hFFFFFF00, 4'hE, v);
      rd(CTRL_OFS, '0, "ctrl lanes");
      wr(ACTV_OFS, '1);
      rd(ACTV_OFS, '0, "active ro");
      rd(5'h14, '0, "unmapped");
      wr(XOFF_OFS, '0);
      for (int r = 0; r < 4; r++) begin
         wr(ROFF_OFS, 32'h00002000);
         wr(CTRL_OFS, (32'(r) << CTRL_RANGE_LSB) | 32'h1);
         meas(100, cnt, mg);
         check(cnt, exp_cnt(100, -8192, lens[r]), "rc gate");
         check(mg <= 2 * STAGE_CLK, 1'b1, "rc gap");
         check(osc_active, 1'b1, "rc active");
         wr(CTRL_OFS, '0);
         meas(100, cnt, mg);
         check(cnt, 100, "xt plain");
         check(osc_active, 1'b0, "xt active");
      end
      wr(ROFF_OFS, 32'h00001FFF);
      wr(CTRL_OFS, 32'h31);
      meas(100, cnt, mg);
      check(cnt, exp_cnt(100, 8191, lens[3]), "rc insert");
      wr(CTRL_OFS, 32'h01);
      rd(ACTV_OFS, 32'h31, "active held");
      // Coarse mode, full extended slowdown and offset -64
      wr(XOFF_OFS, 32'h40);
      wr(CTRL_OFS, 32'h0E);
      meas(1700, cnt, mg);
      e = exp_cnt(1700, -64 - 3 * int'(EXT_STEPS_COARSE), 262144);
      check(cnt, e, "xt gate");
      check(mg <= 2 * STAGE_CLK, 1'b1, "xt gap");
      give_verdict;
   end
   // Tests need about 42k cycles; cut off at 96k, a bit over twice that
   initial begin
      #2400000;
      failures++;
      give_verdict;
   end
endmodule
